//--- rtl/wdit_timer.sv
// Watchdog / interval timer with its three registers on an APB slave port.
// Assumes APB signals come from logic on clk; nrst is the chip reset.
//
// Function
// - Clock select picks divide by 2..8192
// - Control bit 3 picks power-on or manual reset
// - Control bit 4 enables watchdog reset request
// - Control bit 5 runs the counter
// - Control bit 6 picks interval or watchdog mode
// - Control bit 7 gates the interrupt request
// - Watchdog-mode overflow sets status bit 0
// - Interval-mode overflow sets status bit 1
// - Status is read-only, cleared by reset
// - Counter counts ticks, software reads and writes
// - Wrap from all ones gives overflow
// - Counter and control reset to zero
// - Reading status clears overflow flags
// - Watchdog overflow raises interrupt and reset request
// - Interval overflow raises periodic interrupts
`include "wdit_defines.svh"

module wdit_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Requests toward interrupt controller and power management
  output logic timer_irq,
  output logic power_on_reset_request,
  output logic manual_reset_request
);
  import wdit_pkg::*;

  function automatic logic [`WDIT_PRE_W-1:0] div_mask(input wdit_div_t sel);
    case (sel)
      WDIT_DIV2: div_mask = `WDIT_MASK_DIV2;
      WDIT_DIV8: div_mask = `WDIT_MASK_DIV8;
      WDIT_DIV32: div_mask = `WDIT_MASK_DIV32;
      WDIT_DIV64: div_mask = `WDIT_MASK_DIV64;
      WDIT_DIV256: div_mask = `WDIT_MASK_DIV256;
      WDIT_DIV512: div_mask = `WDIT_MASK_DIV512;
      WDIT_DIV2048: div_mask = `WDIT_MASK_DIV2048;
      WDIT_DIV8192: div_mask = `WDIT_MASK_DIV8192;
      default: div_mask = `WDIT_MASK_DIV2;
    endcase
  endfunction

  wdit_byte_t watchdog_control_q;
  logic [1:0] overflow_status_q;
  logic [1:0] overflow_status_d;
  wdit_byte_t tick_counter_q;
  wdit_byte_t tick_counter_d;
  logic [`WDIT_PRE_W-1:0] prescale_q;
  logic por_req_q;
  logic man_req_q;

  // Control fields
  wire wdit_div_t divider_select = wdit_div_t'(
    watchdog_control_q[`WDIT_CTL_DIV_MSB:`WDIT_CTL_DIV_LSB]);
  wire logic reset_kind_select = watchdog_control_q[`WDIT_CTL_RST_KIND];
  wire logic chip_reset_enable = watchdog_control_q[`WDIT_CTL_RST_EN];
  wire logic timer_run_enable = watchdog_control_q[`WDIT_CTL_RUN];
  wire wdit_mode_t mode_select = wdit_mode_t'(watchdog_control_q[`WDIT_CTL_MODE]);
  wire logic irq_enable = watchdog_control_q[`WDIT_CTL_IRQ_EN];

  // Bus decode
  wire logic access = psel & penable;
  wire logic hit_control = (paddr == `WDIT_ADDR_CONTROL);
  wire logic hit_status = (paddr == `WDIT_ADDR_STATUS);
  wire logic hit_counter = (paddr == `WDIT_ADDR_COUNTER);
  wire logic wr_control = access & pwrite & hit_control;
  wire logic wr_counter = access & pwrite & hit_counter;
  wire logic rd_status = access & ~pwrite & hit_status;
  // Status is read-only, so a write there is refused too
  wire logic bad_access = ~(hit_control | hit_counter | (hit_status & ~pwrite));

  // Tick and overflow
  wire logic [`WDIT_PRE_W-1:0] mask = div_mask(divider_select);
  wire logic tick = timer_run_enable & ((prescale_q & mask) == mask);
  // A counter write in the same cycle wins and cancels the wrap
  wire logic overflow = tick & (tick_counter_q == 8'hff) & ~wr_counter;
  wire logic guard_ovf = overflow & (mode_select == WDIT_MODE_GUARD);
  wire logic periodic_ovf = overflow & (mode_select == WDIT_MODE_INTERVAL);
  wire logic want_reset = guard_ovf & chip_reset_enable;

  // Read clear first, then set, so a coincident overflow survives
  always_comb begin
    overflow_status_d = overflow_status_q;
    if (rd_status) begin
      overflow_status_d = `WDIT_STATUS_RST;
    end
    if (guard_ovf) begin
      overflow_status_d[`WDIT_STS_GUARD] = 1'b1;
    end
    if (periodic_ovf) begin
      overflow_status_d[`WDIT_STS_PERIODIC] = 1'b1;
    end
  end

  always_comb begin
    tick_counter_d = tick_counter_q;
    if (wr_counter) begin
      tick_counter_d = pwpick(pwdata);
    end else if (tick) begin
      tick_counter_d = tick_counter_q + 8'h01;
    end
  end

  function automatic wdit_byte_t pwpick(input logic [31:0] w);
    pwpick = w[7:0];
  endfunction

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      watchdog_control_q <= `WDIT_CONTROL_RST;
    end else if (wr_control) begin
      watchdog_control_q <= pwpick(pwdata);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      overflow_status_q <= `WDIT_STATUS_RST;
      tick_counter_q <= `WDIT_COUNTER_RST;
    end else begin
      overflow_status_q <= overflow_status_d;
      tick_counter_q <= tick_counter_d;
    end
  end

  // Prescaler restarts while stopped so the first tick is a full period
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prescale_q <= '0;
    end else if (!timer_run_enable) begin
      prescale_q <= '0;
    end else begin
      prescale_q <= prescale_q + 1'b1;
    end
  end

  // One-cycle reset request pulses
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      por_req_q <= 1'b0;
      man_req_q <= 1'b0;
    end else begin
      por_req_q <= want_reset & ~reset_kind_select;
      man_req_q <= want_reset & reset_kind_select;
    end
  end

  // Read data
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= '0;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= hit_control ? {24'h000000, watchdog_control_q} :
                hit_status ? {30'h00000000, overflow_status_q} :
                hit_counter ? {24'h000000, tick_counter_q} : 32'h00000000;
    end
  end

  assign pready = 1'b1;
  assign pslverr = access & bad_access;
  // Level request until the flags are read away
  assign timer_irq = irq_enable & (|overflow_status_q);
  assign power_on_reset_request = por_req_q;
  assign manual_reset_request = man_req_q;

endmodule // wdit_timer

//--- rtl/wdit_defines.svh
// Offsets, field positions, reset values and divider constants for the
// watchdog / interval timer. Assumes a 32-bit byte-addressed peripheral bus.
`ifndef WDIT_DEFINES_SVH
`define WDIT_DEFINES_SVH

// Register byte addresses
`define WDIT_ADDR_CONTROL 32'h0900_1100
`define WDIT_ADDR_STATUS 32'h0900_1104
`define WDIT_ADDR_COUNTER 32'h0900_1108

// Control field positions
`define WDIT_CTL_DIV_LSB 0
`define WDIT_CTL_DIV_MSB 2
`define WDIT_CTL_RST_KIND 3
`define WDIT_CTL_RST_EN 4
`define WDIT_CTL_RUN 5
`define WDIT_CTL_MODE 6
`define WDIT_CTL_IRQ_EN 7

// Status field positions
`define WDIT_STS_GUARD 0
`define WDIT_STS_PERIODIC 1

// Reset values
`define WDIT_CONTROL_RST 8'h00
`define WDIT_STATUS_RST 2'h0
`define WDIT_COUNTER_RST 8'h00

// Prescaler masks: tick when the low bits are all ones (divide by 2^n)
`define WDIT_PRE_W 13
`define WDIT_MASK_DIV2 13'h0001
`define WDIT_MASK_DIV8 13'h0007
`define WDIT_MASK_DIV32 13'h001f
`define WDIT_MASK_DIV64 13'h003f
`define WDIT_MASK_DIV256 13'h00ff
`define WDIT_MASK_DIV512 13'h01ff
`define WDIT_MASK_DIV2048 13'h07ff
`define WDIT_MASK_DIV8192 13'h1fff

`endif

//--- rtl/wdit_pkg.sv
// Types shared by the watchdog / interval timer.
// Assumes the constants header is included by the design file.
package wdit_pkg;

  typedef logic [7:0] wdit_byte_t;

  typedef enum logic [2:0] {
    WDIT_DIV2 = 3'b000,
    WDIT_DIV8 = 3'b001,
    WDIT_DIV32 = 3'b010,
    WDIT_DIV64 = 3'b011,
    WDIT_DIV256 = 3'b100,
    WDIT_DIV512 = 3'b101,
    WDIT_DIV2048 = 3'b110,
    WDIT_DIV8192 = 3'b111
  } wdit_div_t;

  typedef enum logic {
    WDIT_MODE_INTERVAL = 1'b0,
    WDIT_MODE_GUARD = 1'b1
  } wdit_mode_t;

endpackage

//--- test/wdit_timer_checker.sv
// Checker of the timer's bus and request ports.
// Assumes it is bound into wdit_timer.
`include "wdit_defines.svh"
module wdit_timer_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic timer_irq,
  input wire logic power_on_reset_request,
  input wire logic manual_reset_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire acc = psel && penable, por = power_on_reset_request, mnr = manual_reset_request;
  wire sts = paddr == `WDIT_ADDR_STATUS, ctl = paddr == `WDIT_ADDR_CONTROL;
  wire hit = sts || ctl || paddr == `WDIT_ADDR_COUNTER;
  a_por_one_cycle: assert property (por |=> !por) else $error("long por");
  a_mnr_one_cycle: assert property (mnr |=> !mnr) else $error("long mnr");
  a_one_kind: assert property (!(por && mnr)) else $error("two kinds");
  a_status_ro: assert property (acc && pwrite && sts |-> pslverr) else $error("sts write");
  a_hole_err: assert property (acc && !hit |-> pslverr) else $error("hole ok");
  a_reg_ok: assert property (acc && hit && !(pwrite && sts) |-> !pslverr) else $error("reg err");
  a_hole_zero: assert property (psel && !penable && !pwrite && !hit |=> prdata == 32'h0)
    else $error("hole data");
  a_irq_gated: assert property (acc && pwrite && ctl && !pwdata[7] |=> !timer_irq)
    else $error("irq unmasked");
  c_por: cover property (por);
  c_mnr: cover property (mnr);
  c_irq: cover property (timer_irq);
endmodule // wdit_timer_checker
bind wdit_timer wdit_timer_checker u_chk (.*);

//--- test/wdit_pmu_model.sv
// Power management side: tallies reset request pulses.
// Assumes requests are one-cycle pulses on clk.
module wdit_pmu_model (
  input wire logic clk,
  input wire logic power_on_reset_request,
  input wire logic manual_reset_request
);
  int por_seen = 0, manual_seen = 0;
  always @(posedge clk) por_seen <= por_seen + power_on_reset_request;
  always @(posedge clk) manual_seen <= manual_seen + manual_reset_request;
endmodule // wdit_pmu_model

//--- test/test_wdit_timer.sv
// Bench for the timer; bus driven at the falling edge.
// Assumes two-cycle accesses, no wait states.
`include "wdit_defines.svh"
module test_wdit_timer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ctl_a = `WDIT_ADDR_CONTROL, sts_a = `WDIT_ADDR_STATUS;
  localparam logic [31:0] cnt_a = `WDIT_ADDR_COUNTER;
  logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic pready, pslverr, timer_irq, power_on_reset_request, manual_reset_request;
  int num_errors = 0, check_count = 0, sh[8] = '{1, 3, 5, 6, 8, 9, 11, 13};
  logic [7:0] cfg[5] = '{8'h20, 8'ha0, 8'he0, 8'hf0, 8'hf8};
  wdit_timer uut (.*);
  wdit_pmu_model pmu (.*);
  initial forever #12.5 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(negedge clk);
    {psel, pwrite, paddr, pwdata} = {1'b1, wr, a, d};
    @(negedge clk);
    penable = 1;
    chk(pready, 32'h1);
    @(negedge clk);
    {psel, penable} = 2'h0;
    if (!wr) chk(prdata, d);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    close_out;
  end
  initial begin
    repeat (16) @(negedge clk);
    nrst = 1;
    for (int i = 0; i < 4; i++) bus(0, ctl_a + 32'(4 * i), 32'h0);
    bus(1, sts_a, 32'h3);
    bus(0, sts_a, 32'h0);
    for (int k = 0; k < 8; k++) begin
      bus(1, cnt_a, 32'(k));
      bus(1, ctl_a, 32'h20 | 32'(k));
      repeat ((4 << sh[k]) - 3) @(negedge clk);
      bus(1, ctl_a, 32'h0);
      repeat (20) @(negedge clk);
      bus(0, cnt_a, 32'(k + 4));
    end
    for (int i = 0; i < 5; i++) begin
      bus(1, cnt_a, 32'hfe);
      bus(1, ctl_a, 32'(cfg[i]));
      repeat (6) @(negedge clk);
      bus(1, ctl_a, 32'(cfg[i] & 8'h80));
      chk(timer_irq, cfg[i][7]);
      bus(0, sts_a, cfg[i][6] ? 32'h1 : 32'h2);
      chk(timer_irq, 0);
      chk(pmu.por_seen, i > 2);
      chk(pmu.manual_seen, i > 3);
    end
    close_out;
  end
endmodule // test_wdit_timer
